// file: design/fbep_pkg.sv
// Constants, types and helpers for the flash array and protection logic
package fbep_pkg;
	localparam int FLASH_BYTES = 32768;
	localparam int WORD_BYTES = 4;
	localparam int WORDS = FLASH_BYTES / WORD_BYTES;
	localparam int AW = $clog2(WORDS);
	localparam int ERASE_BYTES = 1024;
	localparam int BLK_WORDS = ERASE_BYTES / WORD_BYTES;
	localparam int BLK_WAW = $clog2(BLK_WORDS);
	localparam int BLK_AW = AW - BLK_WAW;
	localparam int PROT_BYTES = 2048;
	localparam int PROT_UNITS = FLASH_BYTES / PROT_BYTES;
	localparam int PU_AW = $clog2(PROT_UNITS);
	localparam int DW = 32;
	localparam logic [DW-1:0] ERASED_WORD = 32'hffff_ffff;
	localparam logic [DW-1:0] DENIED_WORD = 32'h0000_0000;
	localparam logic [BLK_WAW-1:0] BLK_LAST = 8'hff;
	localparam logic [1:0] SRC_FETCH = 2'h0;
	localparam logic [1:0] SRC_DATA = 2'h1;
	localparam logic [1:0] SRC_DEBUG = 2'h2;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b01,
		ST_ERASE = 2'b10
	} fbep_state_t;

	// Protection unit of a word address
	function automatic logic [PU_AW-1:0] pu_of_word(input logic [AW-1:0] a);
		pu_of_word = a[AW-1 -: PU_AW];
	endfunction

	// Protection unit of an erase block
	function automatic logic [PU_AW-1:0] pu_of_blk(input logic [BLK_AW-1:0] b);
		pu_of_blk = b[BLK_AW-1 -: PU_AW];
	endfunction
endpackage

// file: design/fbep_flash.sv
// Flash array with block erase, word program and unit protection
`timescale 1ns/100ps
module fbep_flash (
	input  wire logic                                clk,
	input  wire logic                                reset_n,
	input  wire logic [fbep_pkg::PROT_UNITS-1:0]     prot_ro,
	input  wire logic [fbep_pkg::PROT_UNITS-1:0]     prot_xo,
	input  wire logic                                rd_req,
	input  wire logic [1:0]                          rd_src,
	input  wire logic [fbep_pkg::AW-1:0]             rd_addr,
	output logic      [fbep_pkg::DW-1:0]             rd_data_ff,
	output logic                                     rd_valid_ff,
	output logic                                     rd_deny_ff,
	input  wire logic                                prog_req,
	input  wire logic [fbep_pkg::AW-1:0]             prog_addr,
	input  wire logic [fbep_pkg::DW-1:0]             prog_data,
	input  wire logic                                erase_req,
	input  wire logic [fbep_pkg::BLK_AW-1:0]         erase_blk,
	output logic                                     busy_ff,
	output logic                                     op_done_ff,
	output logic                                     op_deny_ff
);
	// Array storage
	logic [fbep_pkg::DW-1:0] mem [fbep_pkg::WORDS];

	fbep_pkg::fbep_state_t           state_ff;
	fbep_pkg::fbep_state_t           nxt_state;
	logic [fbep_pkg::BLK_WAW-1:0]    cnt_ff;
	logic [fbep_pkg::BLK_WAW-1:0]    nxt_cnt;
	logic [fbep_pkg::BLK_AW-1:0]     blk_ff;
	logic [fbep_pkg::BLK_AW-1:0]     nxt_blk;
	logic                            nxt_busy;
	logic                            nxt_done;
	logic                            nxt_deny;
	logic                            mem_we;
	logic [fbep_pkg::AW-1:0]         mem_waddr;
	logic [fbep_pkg::DW-1:0]         mem_wdata;
	logic [fbep_pkg::DW-1:0]         nxt_rd_data;
	logic                            nxt_rd_valid;
	logic                            nxt_rd_deny;
	logic                            rd_ok;
	logic [fbep_pkg::PU_AW-1:0]      rd_pu;
	logic [fbep_pkg::PU_AW-1:0]      er_pu;
	logic [fbep_pkg::PU_AW-1:0]      pg_pu;
	logic                            er_lock;
	logic                            pg_lock;

	// Erase or program barred in this unit
	function automatic logic unit_locked(
		input logic [fbep_pkg::PROT_UNITS-1:0] ro,
		input logic [fbep_pkg::PROT_UNITS-1:0] xo,
		input logic [fbep_pkg::PU_AW-1:0]      pu
	);
		unit_locked = ro[pu] | xo[pu];
	endfunction

	// Unit lookups
	always_comb begin
		rd_pu = fbep_pkg::pu_of_word(rd_addr);
		er_pu = fbep_pkg::pu_of_blk(erase_blk);
		pg_pu = fbep_pkg::pu_of_word(prog_addr);
		er_lock = unit_locked(prot_ro, prot_xo, er_pu);
		pg_lock = unit_locked(prot_ro, prot_xo, pg_pu);
		rd_ok = ~prot_xo[rd_pu] | (rd_src == fbep_pkg::SRC_FETCH);
	end

	// Erase and program sequencing
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_blk = blk_ff;
		nxt_done = 1'b0;
		nxt_deny = 1'b0;
		mem_we = 1'b0;
		mem_waddr = prog_addr;
		mem_wdata = mem[prog_addr] & prog_data;
		unique case (state_ff)
			fbep_pkg::ST_IDLE: begin
				if (erase_req) begin
					if (er_lock) begin
						nxt_deny = 1'b1;
					end else begin
						nxt_state = fbep_pkg::ST_ERASE;
						nxt_blk = erase_blk;
						nxt_cnt = '0;
					end
				end else if (prog_req) begin
					if (pg_lock) begin
						nxt_deny = 1'b1;
					end else begin
						mem_we = 1'b1;
						nxt_done = 1'b1;
					end
				end
			end
			fbep_pkg::ST_ERASE: begin
				mem_we = 1'b1;
				mem_waddr = {blk_ff, cnt_ff};
				mem_wdata = fbep_pkg::ERASED_WORD;
				nxt_cnt = cnt_ff + 1'b1;
				if (cnt_ff == fbep_pkg::BLK_LAST) begin
					nxt_state = fbep_pkg::ST_IDLE;
					nxt_done = 1'b1;
				end
			end
		endcase
		nxt_busy = (nxt_state == fbep_pkg::ST_ERASE);
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state_ff <= fbep_pkg::ST_IDLE;
			cnt_ff <= '0;
			blk_ff <= '0;
			busy_ff <= 1'b0;
			op_done_ff <= 1'b0;
			op_deny_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			blk_ff <= nxt_blk;
			busy_ff <= nxt_busy;
			op_done_ff <= nxt_done;
			op_deny_ff <= nxt_deny;
		end
	end

	// Array write port
	always_ff @(posedge clk) begin
		if (reset_n && mem_we) begin
			mem[mem_waddr] <= mem_wdata;
		end
	end

	// Read path
	always_comb begin
		nxt_rd_valid = rd_req & rd_ok;
		nxt_rd_deny = rd_req & ~rd_ok;
		nxt_rd_data = fbep_pkg::DENIED_WORD;
		if (rd_req && rd_ok) begin
			nxt_rd_data = mem[rd_addr];
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			rd_data_ff <= fbep_pkg::DENIED_WORD;
			rd_valid_ff <= 1'b0;
			rd_deny_ff <= 1'b0;
		end else begin
			rd_data_ff <= nxt_rd_data;
			rd_valid_ff <= nxt_rd_valid;
			rd_deny_ff <= nxt_rd_deny;
		end
	end
endmodule // fbep_flash

// file: tb/fbep_chk.sv
// Checker for flash read, erase and protection timing
`timescale 1ns/100ps
module fbep_chk (
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic [15:0] prot_ro,
	input wire logic [15:0] prot_xo,
	input wire logic        rd_req,
	input wire logic [1:0]  rd_src,
	input wire logic [12:0] rd_addr,
	input wire logic [31:0] rd_data_ff,
	input wire logic        rd_valid_ff,
	input wire logic        rd_deny_ff,
	input wire logic        erase_req,
	input wire logic [4:0]  erase_blk,
	input wire logic        busy_ff,
	input wire logic        op_done_ff,
	input wire logic        op_deny_ff
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	AST_RD_ANS: assert property (rd_req |=> rd_valid_ff != rd_deny_ff)
		else $error("read not answered once");
	AST_RD_IDLE: assert property (!rd_req |=> !rd_valid_ff && !rd_deny_ff)
		else $error("read answer without request");
	AST_XO_DENY: assert property (rd_req && rd_src != 2'h0
		&& prot_xo[rd_addr[12:9]] |=> rd_deny_ff && rd_data_ff == 32'h0)
		else $error("locked read served");
	AST_FETCH: assert property (rd_req && (rd_src == 2'h0
		|| !prot_xo[rd_addr[12:9]]) |=> rd_valid_ff)
		else $error("allowed read refused");
	AST_LOCK: assert property (erase_req && !busy_ff && (prot_ro[erase_blk[4:1]]
		|| prot_xo[erase_blk[4:1]]) |=> op_deny_ff && !busy_ff)
		else $error("locked erase not refused");
	AST_ER_GO: assert property (erase_req && !busy_ff && !prot_ro[erase_blk[4:1]]
		&& !prot_xo[erase_blk[4:1]] |=> busy_ff)
		else $error("erase not started");
	AST_ER_LEN: assert property ($rose(busy_ff) |-> ##256 op_done_ff && !busy_ff)
		else $error("erase length wrong");
	AST_ER_END: assert property ($fell(busy_ff) |-> op_done_ff)
		else $error("erase end without done");
endmodule // fbep_chk
bind fbep_flash fbep_chk i_fbep_chk (.*);

// file: tb/fbep_host.sv
// Fetch, data and debug read requester model
`timescale 1ns/100ps
module fbep_host (
	input  wire logic        clk,
	output logic             rd_req,
	output logic [1:0]       rd_src,
	output logic [12:0]      rd_addr
);
	initial begin
		rd_req = 1'b0;
		rd_src = 2'h0;
		rd_addr = 13'h0;
	end
	task automatic rd(input logic [1:0] s, input logic [12:0] a);
		@(posedge clk) #1;
		rd_req = 1'b1;
		rd_src = s;
		rd_addr = a;
		@(posedge clk) #1;
		rd_req = 1'b0;
		rd_addr = ~a;
	endtask
endmodule // fbep_host

// file: tb/flash_block_erase_protect_test.sv
// Bench for flash erase, program and protection
`timescale 1ns/100ps
module flash_block_erase_protect_test;
	logic        clk, reset_n, rd_req, prog_req, erase_req, rd_valid_ff;
	logic        rd_deny_ff, busy_ff, op_done_ff, op_deny_ff;
	logic [15:0] prot_ro, prot_xo;
	logic [1:0]  rd_src;
	logic [12:0] rd_addr, prog_addr;
	logic [31:0] rd_data_ff, prog_data;
	logic [4:0]  erase_blk;
	int          n_mismatch, total_checks, cyc;
	fbep_flash i_fbep_flash (.*);
	fbep_host i_fbep_host (.*);
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			n_mismatch++;
			test_done;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic op(input logic e, input logic [12:0] a,
		input logic [31:0] d, input logic dn);
		int n;
		n = 0;
		@(posedge clk) #1;
		erase_req = e;
		prog_req = !e;
		erase_blk = a[4:0];
		prog_addr = a;
		prog_data = d;
		@(posedge clk) #1;
		erase_req = 1'b0;
		prog_req = 1'b0;
		chk({31'h0, busy_ff}, {31'h0, e && !dn});
		while (n < 300 && !op_done_ff && !op_deny_ff) begin
			@(posedge clk) #1;
			n++;
		end
		chk({30'h0, op_done_ff, op_deny_ff}, {30'h0, !dn, dn});
		chk(n, (e && !dn) ? fbep_pkg::BLK_WORDS : 0);
	endtask
	task automatic r(input logic [1:0] s, input logic [12:0] a,
		input logic [31:0] x, input logic dn);
		i_fbep_host.rd(s, a);
		chk(rd_data_ff, x);
		chk({30'h0, rd_valid_ff, rd_deny_ff}, {30'h0, !dn, dn});
	endtask
	task automatic t_erase;
		op(1'b1, 13'h2, 0, 1'b0);
		op(1'b1, 13'h3, 0, 1'b0);
		op(1'b1, 13'h1f, 0, 1'b0);
		r(2'h1, 13'h3ff, 32'hffff_ffff, 1'b0);
		r(2'h2, 13'h1fff, 32'hffff_ffff, 1'b0);
		op(1'b0, 13'h310, 32'h0, 1'b0);
		op(1'b0, 13'h210, 32'h1234_5678, 1'b0);
		op(1'b1, 13'h2, 0, 1'b0);
		r(2'h0, 13'h210, 32'hffff_ffff, 1'b0);
		r(2'h1, 13'h310, 32'h0, 1'b0);
	endtask
	task automatic t_prot;
		prot_ro = 16'h0002;
		op(1'b0, 13'h3f0, 32'h0, 1'b1);
		chk({31'h0, op_deny_ff}, 32'h1);
		op(1'b1, 13'h3, 0, 1'b1);
		r(2'h1, 13'h310, 32'h0, 1'b0);
		r(2'h1, 13'h3f0, 32'hffff_ffff, 1'b0);
		prot_ro = 16'h0;
		prot_xo = 16'h0002;
		r(2'h0, 13'h3f0, 32'hffff_ffff, 1'b0);
		r(2'h1, 13'h3f0, 32'h0, 1'b1);
		r(2'h2, 13'h200, 32'h0, 1'b1);
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		{cyc, n_mismatch, total_checks} = 0;
		{reset_n, prog_req, erase_req, prot_ro, prot_xo} = 0;
		{erase_blk, prog_addr, prog_data} = 0;
		repeat (16) @(posedge clk);
		#1 reset_n = 1'b1;
		t_erase;
		t_prot;
		test_done;
	end
endmodule // flash_block_erase_protect_test
